//--- logic/gpio_one_bit_port.sv
// One-bit general-purpose port whose pin doubles as the wait-request input.
// Assumes an APB master on pclk and standby levels from the power controller on pclk.
//
// Operation
// R1: Direction bit 0 set drives the pin; clear makes it an input.
// R2: Direction register is write-only and reads back all ones.
// R3: Direction register loads 0x80 on reset and hardware standby.
// R4: Software standby keeps direction; an output pin keeps its level.
// R5: Data register is 8-bit read/write; bit 0 is the pin output value.
// R6: With direction bit set, a read returns the stored data bit.
// R7: Data bit 7 ignores writes and always reads one.
// R8: Bits 6, 2, 1 store; read stored if direction one, else one.
// R9: Bits 5 to 3 store; read stored if direction one, else undefined.
// R10: Data register loads 0x80 on reset and hardware standby, keeps in software standby.
// R11: The pin is also the active-low wait request from external logic.
// R12: Low pin in T2 of a three-state access with waits enabled inserts a wait.
// R13: With direction bit 0 clear, data bit 0 reads the sampled pin.
// R14: Writes take effect at access completion; fixed bits keep their values.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module gpio_one_bit_port
	import gpio_one_bit_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power modes
	input wire logic sw_standby,
	input wire logic hw_standby,
	// Port pin
	input wire logic port_pin_zero_in,
	output logic port_pin_zero_out,
	output logic port_pin_zero_oe,
	// Bus controller wait interface
	input wire logic wait_enable,
	input wire logic bus_t2,
	input wire logic bus_tw,
	output logic insert_wait
);
	// Address decode used by read and write paths
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		addr_hit = (a == r);
	endfunction : addr_hit

	bus_st_t state_q;
	bus_st_t state_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [7:0] port_direction_reg_q;
	logic [7:0] port_direction_reg_d;
	logic [7:0] port_data_reg_q;
	logic [7:0] port_data_reg_d;
	logic pin_out_q;
	logic pin_out_d;
	logic pin_oe_q;
	logic pin_oe_d;
	logic pin_level;
	logic [7:0] data_read;
	logic mapped;
	logic wr_done;

	// Pin level crosses into pclk before anything looks at it
	pin_sync2 u_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_pin_zero_in),
		.sync_out(pin_level)
	);

	// Wait request sampled from the same synchronised level
	wait_sampler u_wait
	(
		.pclk(pclk),
		.presetn(presetn),
		.wait_enable(wait_enable),
		.bus_t2(bus_t2),
		.bus_tw(bus_tw),
		.wait_req_n(pin_level),
		.insert_wait(insert_wait)
	);

	// Data read value, built per bit from the direction setting
	assign data_read[7] = 1'b1; // [R7]
	assign data_read[PIN_BIT] = port_direction_reg_q[PIN_BIT] ?
		port_data_reg_q[PIN_BIT] : pin_level; // [R6] [R13]
	genvar gi;
	generate
		for (gi = 1; gi < 7; gi++)
		begin : g_rd
			if (ONES_GROUP_MASK[gi])
			begin : g_ones
				assign data_read[gi] = port_direction_reg_q[gi] ?
					port_data_reg_q[gi] : 1'b1; // [R8]
			end
			else
			begin : g_undef
				// Undefined read is given a fixed zero so the bus never carries X
				assign data_read[gi] = port_direction_reg_q[gi] ?
					port_data_reg_q[gi] : UNDEF_READ_VALUE[gi]; // [R9]
			end
		end
	endgenerate

	assign mapped = addr_hit(paddr, DIR_ADDR) | addr_hit(paddr, DATA_ADDR);
	assign wr_done = (state_q == BUS_RESP) & psel & penable & pwrite;

	// Bus handshake: one wait cycle, then a registered answer
	always_comb
	begin
		state_d = state_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		case (state_q)
			BUS_IDLE:
			begin
				if (psel && penable)
				begin
					state_d = BUS_RESP;
					pready_d = 1'b1;
					pslverr_d = ~mapped;
					prdata_d = 32'h0000_0000;
					if (!pwrite && addr_hit(paddr, DIR_ADDR))
					begin
						prdata_d = {24'h00_0000, DIR_READ_VALUE}; // [R2]
					end
					else if (!pwrite && addr_hit(paddr, DATA_ADDR))
					begin
						prdata_d = {24'h00_0000, data_read}; // [R5]
					end
				end
			end
			BUS_RESP:
			begin
				state_d = BUS_IDLE;
			end
			default:
			begin
				state_d = BUS_IDLE;
			end
		endcase
	end

	// Bus state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= BUS_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Register file: hardware standby wins, software standby freezes everything
	always_comb
	begin
		port_direction_reg_d = port_direction_reg_q;
		port_data_reg_d = port_data_reg_q;
		if (hw_standby)
		begin
			port_direction_reg_d = DIR_RESET; // [R3]
			port_data_reg_d = DATA_RESET; // [R10]
		end
		else if (!sw_standby && wr_done) // [R4] [R14]
		begin
			if (addr_hit(paddr, DIR_ADDR))
			begin
				port_direction_reg_d = pwdata[7:0] | FIXED_ONE_MASK; // [R14]
			end
			if (addr_hit(paddr, DATA_ADDR))
			begin
				port_data_reg_d = pwdata[7:0] | FIXED_ONE_MASK; // [R5] [R7]
			end
		end
	end

	// Pin drivers mirror bit 0; they hold through software standby as the registers do
	always_comb
	begin
		pin_out_d = port_data_reg_d[PIN_BIT];
		pin_oe_d = port_direction_reg_d[PIN_BIT]; // [R1] [R4]
	end

	// Register and pin flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_direction_reg_q <= DIR_RESET; // [R3]
			port_data_reg_q <= DATA_RESET; // [R10]
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
		end
		else
		begin
			port_direction_reg_q <= port_direction_reg_d;
			port_data_reg_q <= port_data_reg_d;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign port_pin_zero_out = pin_out_q;
	assign port_pin_zero_oe = pin_oe_q;

	// Checks on the register file, pin and wait path
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_dir;
	logic rd_data;
	assign rd_dir = pready_q & ~pwrite & addr_hit(paddr, DIR_ADDR);
	assign rd_data = pready_q & ~pwrite & addr_hit(paddr, DATA_ADDR);

	dir_reads_ones_a: assert property (rd_dir |-> prdata_q == 32'h0000_00FF) // [R2]
		else $error("direction read not all ones");

	pin_drive_a: assert property (wr_done && !sw_standby && !hw_standby &&
		addr_hit(paddr, DIR_ADDR) |=>
		port_pin_zero_oe == $past(pwdata[PIN_BIT])) // [R1]
		else $error("pin enable does not follow direction write");

	pin_oe_track_a: assert property (##1 port_pin_zero_oe == $past(port_direction_reg_q[0])
		|| $past(port_direction_reg_q[0]) != port_direction_reg_q[0]) // [R1]
		else $error("pin enable differs from direction bit");

	hw_standby_load_a: assert property (hw_standby |=>
		port_direction_reg_q == 8'h80 && port_data_reg_q == 8'h80) // [R3] [R10]
		else $error("hardware standby did not load 0x80");

	sw_standby_hold_a: assert property (sw_standby && !hw_standby |=>
		$stable(port_direction_reg_q) && $stable(port_data_reg_q)
		&& $stable(port_pin_zero_out)) // [R4] [R10]
		else $error("software standby changed state");

	data_bit0_read_a: assert property (rd_data |-> prdata_q[0] == ($past(port_direction_reg_q[0])
		? $past(port_data_reg_q[0]) : $past(pin_level))) // [R6] [R13]
		else $error("data bit 0 read wrong source");

	bit7_fixed_a: assert property (port_data_reg_q[7] and (rd_data |-> prdata_q[7])) // [R7]
		else $error("data bit 7 not one");

	ones_group_read_a: assert property (rd_data |-> (prdata_q[6:1] & 6'h23) ==
		(($past(port_data_reg_q[6:1]) | ~$past(port_direction_reg_q[6:1])) & 6'h23)) // [R8]
		else $error("bits 6, 2, 1 read wrong");

	undef_group_read_a: assert property (rd_data |->
		(prdata_q[5:3] & $past(port_direction_reg_q[5:3])) ==
		($past(port_data_reg_q[5:3]) & $past(port_direction_reg_q[5:3]))) // [R9]
		else $error("bits 5 to 3 read wrong");

	data_write_a: assert property (wr_done && !sw_standby && !hw_standby &&
		addr_hit(paddr, DATA_ADDR) |=> port_data_reg_q == ($past(pwdata[7:0]) | 8'h80)) // [R5] [R14]
		else $error("data write not stored");

	wait_insert_a: assert property (wait_enable && bus_t2 && !pin_level |=> insert_wait) // [R11] [R12]
		else $error("low wait pin in T2 gave no wait");

	answer_time_a: assert property ($rose(psel && penable) |=> pready_q ##1 !pready_q) // [R14]
		else $error("bus answer timing wrong");

	cover_dir_write_c: cover property (wr_done && addr_hit(paddr, DIR_ADDR) ##1 port_pin_zero_oe);
	cover_pin_read_c: cover property (rd_data && !port_direction_reg_q[0]);
	cover_wait_c: cover property (insert_wait [*2]);
	cover_sw_standby_c: cover property (sw_standby && port_pin_zero_oe [*3]);
endmodule : gpio_one_bit_port

//--- logic/gpio_one_bit_pkg.sv
// Constants for the one-bit port with shared wait-request input.
// Assumes an APB master with 32-bit data and word-aligned registers.
package gpio_one_bit_pkg;
	// Printed register offsets are kept as indices; byte address is four times the index
	localparam int ADDR_W = 18;
	localparam logic [15:0] DIR_INDEX = 16'hFFC9;
	localparam logic [15:0] DATA_INDEX = 16'hFFCB;
	localparam logic [ADDR_W-1:0] DIR_ADDR = {DIR_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_INDEX, 2'h0};

	// Values after reset and hardware standby
	localparam logic [7:0] DIR_RESET = 8'h80;
	localparam logic [7:0] DATA_RESET = 8'h80;

	// Read-back fields
	localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
	localparam logic [7:0] FIXED_ONE_MASK = 8'h80;
	localparam logic [7:0] ONES_GROUP_MASK = 8'h46;
	localparam logic [7:0] UNDEF_GROUP_MASK = 8'h38;
	localparam logic [7:0] UNDEF_READ_VALUE = 8'h00;
	localparam int PIN_BIT = 0;

	// Bus answer: one wait cycle in the access phase
	localparam int ANSWER_CYCLES = 1;

	typedef enum logic {BUS_IDLE, BUS_RESP} bus_st_t;
endpackage : gpio_one_bit_pkg

//--- logic/pin_sync2.sv
// Two-stage synchroniser for the port pin level.
// Assumes the pin is asynchronous to pclk; only the second stage leaves the module.
`timescale 1ns/1ps
module pin_sync2
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous level in, synchronised level out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// Next values: first stage feeds only the second
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Pin idles high, so reset both stages to one to avoid a false wait request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : pin_sync2

//--- logic/wait_sampler.sv
// Wait-request sampler for the shared port pin.
// Assumes the bus controller reports its T2 and Tw states on pclk.
`timescale 1ns/1ps
module wait_sampler
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus controller state
	input wire logic wait_enable,
	input wire logic bus_t2,
	input wire logic bus_tw,
	// Synchronised active-low request level
	input wire logic wait_req_n,
	// Wait state request
	output logic insert_wait
);
	logic insert_q;
	logic insert_d;

	// Low pin in T2 starts waits, staying low in Tw keeps them going
	always_comb
	begin
		insert_d = wait_enable & (bus_t2 | bus_tw) & ~wait_req_n; // [R11] [R12]
	end

	// Registered so the request is glitch free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			insert_q <= 1'b0;
		end
		else
		begin
			insert_q <= insert_d;
		end
	end

	assign insert_wait = insert_q;
endmodule : wait_sampler

//--- sim/pin_board_model.sv
// Board-side model of the port pin: an external level source.
// Assumes the port's enable is high while the port drives the pin.
`timescale 1ns/1ps
module pin_board_model
(
	// Clock
	input wire logic pclk,
	// Board drive request and level
	input wire logic board_drive,
	input wire logic board_level,
	// Port side of the pin
	input wire logic pin_out,
	input wire logic pin_oe,
	// Resolved pin level
	output logic pin_level
);
	logic float_q = 1'b0;

	// The pin has no pull, so a floating pin shows a level that changes every cycle
	always @(posedge pclk)
	begin
		float_q <= ~float_q;
	end

	// Port drive wins; a board low requests wait states
	assign pin_level = pin_oe ? pin_out : (board_drive ? board_level : float_q);
endmodule : pin_board_model

//--- sim/one_bit_port_with_wait_input_tb.sv
// Testbench for the one-bit port: APB register tests, standby and wait request.
// Assumes a 10 MHz pclk and the register byte addresses of the package.
`timescale 1ns/1ps
module one_bit_port_with_wait_input_tb;
	import gpio_one_bit_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sw_standby = 1'b0;
	logic hw_standby = 1'b0;
	logic pin_level;
	logic pin_out;
	logic pin_oe;
	logic wait_enable = 1'b0;
	logic bus_t2 = 1'b0;
	logic bus_tw = 1'b0;
	logic insert_wait;
	logic board_drive = 1'b1;
	logic board_level = 1'b1;
	logic [31:0] rd;
	logic err;
	int bad_count = 0;
	int cmp_count = 0;

	gpio_one_bit_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sw_standby(sw_standby), .hw_standby(hw_standby),
		.port_pin_zero_in(pin_level), .port_pin_zero_out(pin_out), .port_pin_zero_oe(pin_oe),
		.wait_enable(wait_enable), .bus_t2(bus_t2), .bus_tw(bus_tw), .insert_wait(insert_wait));

	pin_board_model u_board (.pclk(pclk), .board_drive(board_drive), .board_level(board_level),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

	// Clock at 100 ns period
	initial
	begin
		forever #50 pclk = ~pclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50)
			check("pready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(name, rd, {24'h000000, e});
		check("pslverr", {31'h0, err}, 32'h0);
	endtask : rd_chk

	task automatic pin_chk(input logic e_out, input logic e_oe);
		repeat (2) @(posedge pclk);
		check("pin_oe", {31'h0, pin_oe}, {31'h0, e_oe});
		check("pin_out", {31'h0, pin_out}, {31'h0, e_out});
	endtask : pin_chk

	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// Watchdog: the tests need well under 1000 cycles
	initial
	begin
		#(100 * 20000);
		bad_count++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("dir", DIR_ADDR, 8'hFF);
		rd_chk("data", DATA_ADDR, 8'hC7);
		apb(1'b1, DIR_ADDR, 8'hFF);
		apb(1'b1, DATA_ADDR, 8'h7E);
		rd_chk("data", DATA_ADDR, 8'hFE);
		pin_chk(1'b0, 1'b1);
		apb(1'b1, DATA_ADDR, 8'h01);
		pin_chk(1'b1, 1'b1);
		rd_chk("dir", DIR_ADDR, 8'hFF);
		board_level <= 1'b0;
		apb(1'b1, DIR_ADDR, 8'h00);
		pin_chk(1'b1, 1'b0);
		rd_chk("data", DATA_ADDR, 8'hC6);
		apb(1'b0, 18'h00000, 8'h00);
		check("unmapped", {rd[30:0], err}, 32'h1);
		apb(1'b1, DIR_ADDR, 8'h01);
		sw_standby <= 1'b1;
		apb(1'b1, DATA_ADDR, 8'h00);
		apb(1'b1, DIR_ADDR, 8'h00);
		pin_chk(1'b1, 1'b1);
		sw_standby <= 1'b0;
		rd_chk("data", DATA_ADDR, 8'hC7);
		hw_standby <= 1'b1;
		pin_chk(1'b0, 1'b0);
		hw_standby <= 1'b0;
		rd_chk("data", DATA_ADDR, 8'hC6);
		// Wait request: pin held low by the board
		wait_enable <= 1'b1;
		bus_t2 <= 1'b1;
		repeat (5) @(posedge pclk);
		check("insert_wait", {31'h0, insert_wait}, 32'h1);
		bus_t2 <= 1'b0;
		repeat (3) @(posedge pclk);
		check("insert_wait", {31'h0, insert_wait}, 32'h0);
		bus_tw <= 1'b1;
		repeat (3) @(posedge pclk);
		check("insert_wait", {31'h0, insert_wait}, 32'h1);
		board_level <= 1'b1;
		repeat (5) @(posedge pclk);
		check("insert_wait", {31'h0, insert_wait}, 32'h0);
		board_level <= 1'b0;
		wait_enable <= 1'b0;
		repeat (5) @(posedge pclk);
		check("insert_wait", {31'h0, insert_wait}, 32'h0);
		// Reset in mid-run must bring both registers back from non-reset values
		apb(1'b1, DIR_ADDR, 8'h01);
		apb(1'b1, DATA_ADDR, 8'h01);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pin_chk(1'b0, 1'b0);
		rd_chk("data", DATA_ADDR, 8'hC6);
		give_verdict();
	end
endmodule : one_bit_port_with_wait_input_tb
